// >>> core/bfd_diag.sv
// Purpose: balance switch check and open wire comparison engine
// Assumes: readings arrive already filtered, one word per channel
// Notes: one channel is compared per enabled clock cycle
//
// Design decisions made here: the register addresses and the address-and-strobe port.

// Summary of operation
// - refuse switch check while balancing runs unpaused; counts as abort
// - refuse switch check if over eight switches or three adjacent
// - apply with pause set in the same write turns on the selected test switches
// - selector 0b100 plus go starts the switch check
// - enabled switch passes when aux reading below half main reading
// - switch check done flag set; results in two switch result registers
// - pause off with balancing active restores normal switches; cleared selection plus apply turns all switches off
// - abort sets abort, aux done, switch done; results all ones
// - abort with locked aux selector not above NCH resets aux result to 0x8000
// - refuse invalid aux selector or channel above active cell count
// - refuse unless both converters on and continuous
// - sinks on all sense and balance pins, sources on lowest two
// - codes 0b010 and 0b011 plus go start open wire checks
// - active readings compared to four-bit threshold into result pair
// - open wire check sets its own done flag on completion
// - locked balance channel reading goes to diag aux result
// - bus bar readings used as ordinary cell readings, same filter
module bfd_diag
  import bfd_pkg::*;
#(
  parameter int NCH = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DW-1:0] rdata,
  input wire bfd_conv_t conv,
  input wire logic [NCH*DW-1:0] main_cell_in,
  input wire logic [NCH*DW-1:0] aux_cell_in,
  output logic [MAXCH-1:0] bal_switch_out,
  output logic [MAXCH-1:0] sense_sink_out,
  output logic sense_source_out,
  output logic [MAXCH-1:0] bal_sink_out,
  output logic bal_source_out
);

  localparam logic [4:0] NCH5 = 5'(NCH);
  localparam logic [3:0] LAST = 4'(NCH - 1);
  localparam logic [15:0] CH_MASK = 16'((17'h1 << NCH) - 17'h1);

  if (NCH < 2 || NCH > MAXCH) begin : g_bad_nch
    $error("bfd_diag: NCH must lie between 2 and 16");
  end

  bfd_st_t st_ff;
  bfd_st_t nxt_st;
  logic [15:0] tsel;
  logic go;
  logic apply;
  logic locked;
  logic sel_bad;
  logic over;
  logic conv_ok;
  logic bal_bad;
  logic lim_bad;
  logic refuse;
  logic covered;
  logic active;
  logic fail;
  logic [15:0] mreading;
  logic [15:0] areading;
  logic [15:0] thr16;

  // number of switches selected for test
  function automatic int count_on(input logic [15:0] v);
    int n;
    n = 0;
    for (int i = 0; i < MAXCH; i++) begin
      n = n + int'(v[i]);
    end
    return n;
  endfunction

  // true when more than MAX_ADJ neighbouring switches are on
  function automatic logic run_too_long(input logic [15:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i < MAXCH - MAX_ADJ; i++) begin
      if (&v[i +: MAX_ADJ + 1]) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    tsel = {st_ff.test_hi, st_ff.test_lo};
    go = wr && addr == A_CTRL && wdata[C_GO];
    apply = wr && addr == A_CTRL && wdata[C_APPLY];
    locked = st_ff.aux_sel != 5'h0;
    sel_bad = st_ff.aux_sel > NCH5;
    over = st_ff.aux_sel > st_ff.num_cells;
    conv_ok = conv.main_on && conv.main_cont && conv.aux_on && conv.aux_cont;
    bal_bad = conv.bal_active && !st_ff.pause;
    lim_bad = count_on(tsel) > MAX_SW_ON || run_too_long(tsel);
    refuse = !conv_ok || sel_bad || over;
    if (st_ff.kind == SEL_FET && (bal_bad || lim_bad)) begin
      refuse = 1'b1;
    end
    // bus bar channels are read like any other cell channel
    mreading = main_cell_in[int'(st_ff.idx) * DW +: DW];
    areading = aux_cell_in[int'(st_ff.idx) * DW +: DW];
    covered = !locked || st_ff.aux_sel == 5'({1'b0, st_ff.idx} + 5'h1);
    active = {1'b0, st_ff.idx} < st_ff.num_cells;
    thr16 = 16'({12'h000, st_ff.thr} << OPEN_WIRE_THRESHOLD_SHIFT);
    fail = 1'b0;

    // register writes
    if (wr) begin
      case (addr)
        A_CTRL: begin
          nxt_st.comp_sel = wdata[C_SEL_LSB +: 3];
          nxt_st.sink = wdata[C_SNK_LSB +: 2];
          nxt_st.pause = wdata[C_PAUSE];
          nxt_st.thr = wdata[C_THR_LSB +: 4];
        end
        A_AUXSEL: begin
          nxt_st.aux_sel = wdata[X_SEL_LSB +: 5];
          nxt_st.num_cells = wdata[X_NUM_LSB +: 5];
        end
        A_TSL: nxt_st.test_lo = wdata[7:0];
        A_TSH: nxt_st.test_hi = wdata[7:0];
        A_NORM: nxt_st.normal = wdata & CH_MASK;
        A_MISC: if (wdata[M_ABORT]) nxt_st.abort = 1'b0; // set below wins
        default: ;
      endcase
    end

    // test switch application and release
    if (apply) begin
      nxt_st.applied = tsel & CH_MASK;
    end
    if (!nxt_st.pause) begin
      nxt_st.applied = 16'h0000;
    end
    if (nxt_st.pause) begin
      nxt_st.bal_sw = nxt_st.applied;
    end else if (conv.bal_active) begin
      nxt_st.bal_sw = nxt_st.normal;
    end else begin
      nxt_st.bal_sw = 16'h0000;
    end

    // sinks on all channel pins, sources on the two lowest pins
    nxt_st.sense_sink = nxt_st.sink[0] ? CH_MASK : 16'h0000;
    nxt_st.sense_src = nxt_st.sink[0];
    nxt_st.bal_sink = nxt_st.sink[1] ? CH_MASK : 16'h0000;
    nxt_st.bal_src = nxt_st.sink[1];

    // comparison engine
    case (st_ff.state)
      S_IDLE: begin
        if (go && (wdata[2:0] == SEL_FET || wdata[2:0] == SEL_SOW ||
            wdata[2:0] == SEL_BOW)) begin
          nxt_st.kind = wdata[2:0];
          nxt_st.state = S_CHECK;
          case (wdata[2:0])
            SEL_FET: begin
              nxt_st.done[D_FET] = 1'b0;
              nxt_st.done[D_AUX] = 1'b0;
            end
            SEL_SOW: nxt_st.done[D_SOW] = 1'b0;
            default: nxt_st.done[D_BOW] = 1'b0;
          endcase
        end
      end
      S_CHECK: begin
        if (refuse) begin
          nxt_st.abort = 1'b1;
          nxt_st.state = S_IDLE;
          case (st_ff.kind)
            SEL_FET: begin
              nxt_st.done[D_FET] = 1'b1;
              nxt_st.done[D_AUX] = 1'b1;
              nxt_st.fet_res = RES_FAIL_ALL;
            end
            SEL_SOW: begin
              nxt_st.done[D_SOW] = 1'b1;
              nxt_st.sow_res = RES_FAIL_ALL;
            end
            default: begin
              nxt_st.done[D_BOW] = 1'b1;
              nxt_st.bow_res = RES_FAIL_ALL;
            end
          endcase
          if (locked && !sel_bad) begin
            nxt_st.aux_cell_res = AUX_DEFAULT;
          end
        end else begin
          nxt_st.idx = 4'h0;
          nxt_st.work = 16'h0000;
          nxt_st.state = S_RUN;
        end
      end
      S_RUN: begin
        case (st_ff.kind)
          SEL_FET: fail = tsel[st_ff.idx] && covered &&
                          !(areading < (mreading >> 1));
          SEL_SOW: fail = active && mreading < thr16;
          SEL_BOW: fail = active && covered && areading < thr16;
          default: fail = 1'b0;
        endcase
        nxt_st.work[st_ff.idx] = fail;
        if (locked && covered) begin
          nxt_st.aux_cell_res = areading;
          if (st_ff.kind != SEL_SOW) begin
            nxt_st.diag_aux = areading;
          end
        end
        if (st_ff.idx == LAST) begin
          nxt_st.state = S_IDLE;
          case (st_ff.kind)
            SEL_FET: begin
              nxt_st.fet_res = nxt_st.work;
              nxt_st.done[D_FET] = 1'b1;
            end
            SEL_SOW: begin
              nxt_st.sow_res = nxt_st.work;
              nxt_st.done[D_SOW] = 1'b1;
            end
            default: begin
              nxt_st.bow_res = nxt_st.work;
              nxt_st.done[D_BOW] = 1'b1;
            end
          endcase
        end else begin
          nxt_st.idx = st_ff.idx + 4'h1;
        end
      end
      default: nxt_st.state = S_IDLE;
    endcase

    // read data, valid in the cycle after the strobe only
    nxt_st.rdata = 16'h0000;
    if (rd) begin
      case (addr)
        A_CTRL: nxt_st.rdata = {4'h0, st_ff.thr, st_ff.pause, st_ff.sink,
                                2'b00, st_ff.comp_sel};
        A_AUXSEL: nxt_st.rdata = {3'h0, st_ff.num_cells, 3'h0, st_ff.aux_sel};
        A_TSL: nxt_st.rdata = {8'h00, st_ff.test_lo};
        A_TSH: nxt_st.rdata = {8'h00, st_ff.test_hi};
        A_NORM: nxt_st.rdata = st_ff.normal;
        A_STAT: nxt_st.rdata = {12'h000, st_ff.done};
        A_MISC: nxt_st.rdata = {15'h0000, st_ff.abort};
        A_FETL: nxt_st.rdata = {8'h00, st_ff.fet_res[7:0]};
        A_FETH: nxt_st.rdata = {8'h00, st_ff.fet_res[15:8]};
        A_SOWL: nxt_st.rdata = {8'h00, st_ff.sow_res[7:0]};
        A_SOWH: nxt_st.rdata = {8'h00, st_ff.sow_res[15:8]};
        A_BOWL: nxt_st.rdata = {8'h00, st_ff.bow_res[7:0]};
        A_BOWH: nxt_st.rdata = {8'h00, st_ff.bow_res[15:8]};
        A_AUXRES: nxt_st.rdata = st_ff.aux_cell_res;
        A_DIAGAUX: nxt_st.rdata = st_ff.diag_aux;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
      st_ff.num_cells <= NCH5;
      st_ff.aux_cell_res <= AUX_DEFAULT;
      st_ff.diag_aux <= AUX_DEFAULT;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign rdata = st_ff.rdata;
  assign bal_switch_out = st_ff.bal_sw;
  assign sense_sink_out = st_ff.sense_sink;
  assign sense_source_out = st_ff.sense_src;
  assign bal_sink_out = st_ff.bal_sink;
  assign bal_source_out = st_ff.bal_src;

  // checks on the engine
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_go(logic [2:0] code);
    ce && st_ff.state == S_IDLE && wr && addr == A_CTRL && wdata[C_GO] &&
      wdata[2:0] == code;
  endsequence
  sequence s_refuse;
    ce && st_ff.state == S_CHECK && refuse;
  endsequence
  sequence s_last(logic [2:0] code);
    ce && st_ff.state == S_RUN && st_ff.idx == LAST && st_ff.kind == code;
  endsequence
  a_fet_launch: assert property (s_go(SEL_FET) |=>
    st_ff.state == S_CHECK && !st_ff.done[D_FET] && !st_ff.done[D_AUX])
    else $error("switch check not launched");
  a_ow_launch: assert property (s_go(SEL_BOW) |=>
    st_ff.state == S_CHECK && st_ff.kind == SEL_BOW && !st_ff.done[D_BOW])
    else $error("balance open wire check not launched");
  a_bal_refuse: assert property (
    ce && st_ff.state == S_CHECK && st_ff.kind == SEL_FET &&
    conv.bal_active && !st_ff.pause |=> st_ff.abort && st_ff.done[D_FET]
    && st_ff.done[D_AUX] && st_ff.fet_res == 16'hffff &&
    st_ff.state == S_IDLE)
    else $error("unpaused balancing did not abort");
  a_limit_refuse: assert property (
    ce && st_ff.state == S_CHECK && st_ff.kind == SEL_FET && lim_bad
    |=> st_ff.abort && st_ff.state == S_IDLE)
    else $error("switch limits not enforced");
  a_conv_refuse: assert property (
    ce && st_ff.state == S_CHECK && !conv_ok |=> st_ff.abort ##0
    st_ff.state == S_IDLE)
    else $error("converter condition not enforced");
  a_sel_refuse: assert property (
    ce && st_ff.state == S_CHECK && (sel_bad || over) |=>
    st_ff.state == S_IDLE && st_ff.abort &&
    ($stable(st_ff.aux_cell_res) || !$past(sel_bad)))
    else $error("bad aux selector not refused");
  a_aux_default: assert property (
    s_refuse ##0 (locked && !sel_bad) |=> st_ff.aux_cell_res == 16'h8000)
    else $error("aux result not returned to default");
  a_apply_sw: assert property (
    ce && wr && addr == A_CTRL && wdata[C_APPLY] && wdata[C_PAUSE] |=>
    st_ff.bal_sw == ($past(tsel) & CH_MASK))
    else $error("test switches not applied");
  a_pause_exit: assert property (
    ce && wr && addr == A_CTRL && !wdata[C_PAUSE] && conv.bal_active |=>
    st_ff.bal_sw == $past(st_ff.normal) && st_ff.applied == 16'h0000)
    else $error("normal switches not restored");
  a_fet_fail: assert property (
    ce && st_ff.state == S_RUN && st_ff.kind == SEL_FET &&
    tsel[st_ff.idx] && covered && areading >= (mreading >> 1) |=>
    st_ff.work[$past(st_ff.idx)])
    else $error("switch fault not flagged");
  a_fet_done: assert property (s_last(SEL_FET) |=>
    st_ff.done[D_FET] && st_ff.state == S_IDLE &&
    st_ff.fet_res == st_ff.work)
    else $error("switch check did not finish");
  a_ow_done: assert property (s_last(SEL_SOW) |=>
    st_ff.done[D_SOW] && st_ff.sow_res == st_ff.work)
    else $error("sense open wire check did not finish");
  a_bal_pins: assert property (
    ce && wr && addr == A_CTRL |=>
    st_ff.bal_src == $past(wdata[C_SNK_LSB + 1]) &&
    st_ff.bal_sink == ($past(wdata[C_SNK_LSB + 1]) ? CH_MASK : 16'h0000))
    else $error("balance pin sinks wrong");

endmodule

// >>> core/bfd_pkg.sv
// Purpose: shared constants and types for the balance switch and
//   open wire diagnostic comparison engine
// Assumes: 16-bit register port, one reading of 16 bits per channel
// Notes: offsets are word indexes on the plain register port
package bfd_pkg;

  localparam int MAXCH = 16;
  localparam int DW = 16;
  localparam int AW = 4;

  // register offsets
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_AUXSEL = 4'h1;
  localparam logic [3:0] A_TSL = 4'h2;
  localparam logic [3:0] A_TSH = 4'h3;
  localparam logic [3:0] A_NORM = 4'h4;
  localparam logic [3:0] A_STAT = 4'h5;
  localparam logic [3:0] A_MISC = 4'h6;
  localparam logic [3:0] A_FETL = 4'h7;
  localparam logic [3:0] A_FETH = 4'h8;
  localparam logic [3:0] A_SOWL = 4'h9;
  localparam logic [3:0] A_SOWH = 4'ha;
  localparam logic [3:0] A_BOWL = 4'hb;
  localparam logic [3:0] A_BOWH = 4'hc;
  localparam logic [3:0] A_AUXRES = 4'hd;
  localparam logic [3:0] A_DIAGAUX = 4'he;

  // control register fields
  localparam int C_SEL_LSB = 0;
  localparam int C_GO = 3;
  localparam int C_APPLY = 4;
  localparam int C_SNK_LSB = 5;
  localparam int C_PAUSE = 7;
  localparam int C_THR_LSB = 8;
  // aux selector register fields
  localparam int X_SEL_LSB = 0;
  localparam int X_NUM_LSB = 8;
  // status bits
  localparam int D_FET = 0;
  localparam int D_AUX = 1;
  localparam int D_SOW = 2;
  localparam int D_BOW = 3;
  localparam int M_ABORT = 0;

  // comparison selector codes
  localparam logic [2:0] SEL_SOW = 3'h2;
  localparam logic [2:0] SEL_BOW = 3'h3;
  localparam logic [2:0] SEL_FET = 3'h4;

  // limits and fixed values
  localparam int MAX_SW_ON = 8;
  localparam int MAX_ADJ = 2;
  localparam logic [15:0] RES_FAIL_ALL = 16'hffff;
  localparam logic [15:0] AUX_DEFAULT = 16'h8000;
  localparam int OPEN_WIRE_THRESHOLD_SHIFT = 12;

  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_CHECK = 2'h1,
    S_RUN = 2'h3
  } bfd_state_t;

  // converter and balancer condition inputs
  typedef struct packed {
    logic main_on;
    logic main_cont;
    logic aux_on;
    logic aux_cont;
    logic bal_active;
  } bfd_conv_t;

  // complete state of the engine
  typedef struct packed {
    bfd_state_t state;
    logic [3:0] idx;
    logic [2:0] kind;
    logic [2:0] comp_sel;
    logic [1:0] sink;
    logic pause;
    logic [3:0] thr;
    logic [4:0] aux_sel;
    logic [4:0] num_cells;
    logic [7:0] test_lo;
    logic [7:0] test_hi;
    logic [15:0] applied;
    logic [15:0] normal;
    logic [15:0] bal_sw;
    logic [3:0] done;
    logic abort;
    logic [15:0] work;
    logic [15:0] fet_res;
    logic [15:0] sow_res;
    logic [15:0] bow_res;
    logic [15:0] aux_cell_res;
    logic [15:0] diag_aux;
    logic [15:0] rdata;
    logic [15:0] sense_sink;
    logic sense_src;
    logic [15:0] bal_sink;
    logic bal_src;
  } bfd_st_t;

endpackage

// >>> tb/bfd_cell_model.sv
// Purpose: cell front end behind the diagnostic engine's pins
// Assumes: a healthy cell reads 16'h8000 on the main path
// Notes: bench injects faults through bad_fet and open_wire
module bfd_cell_model
  import bfd_pkg::*;
#(
  parameter int NCH = 16
) (
  input wire logic [MAXCH-1:0] bal_switch_in,
  input wire logic [MAXCH-1:0] sense_sink_in,
  input wire logic [MAXCH-1:0] bal_sink_in,
  input wire logic [MAXCH-1:0] bad_fet,
  input wire logic [MAXCH-1:0] open_wire,
  output logic [NCH*DW-1:0] main_cell_out,
  output logic [NCH*DW-1:0] aux_cell_out
);
  // readings follow switch, sink and fault state per channel
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      if (sense_sink_in[k] && open_wire[k]) begin
        main_cell_out[k*DW+:DW] = 16'h0200; // open pin drained by sink
      end else begin
        main_cell_out[k*DW+:DW] = 16'h8000; // no bus bars
      end
      if (bal_sink_in[k] && open_wire[k]) begin
        aux_cell_out[k*DW+:DW] = 16'h0200;
      end else if (bal_switch_in[k] && !bad_fet[k]) begin
        aux_cell_out[k*DW+:DW] = 16'h0100; // closed switch shorts channel
      end else begin
        aux_cell_out[k*DW+:DW] = 16'h7f00;
      end
    end
  end
endmodule

// >>> tb/bfd_diag_bench.sv
// Purpose: self-checking bench of the diagnostic comparison engine
// Assumes: host role played by the bench over the plain register port
// Notes: threshold field 4 gives 16'h4000, between healthy and open
module bfd_diag_bench
  import bfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 16;
  localparam bfd_conv_t CV_OK = 5'b11110;
  localparam logic [15:0] AS_ALL = 16'h1000;
  logic clock, reset_n, ce, wr, rd, s_src, b_src;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, rv;
  bfd_conv_t conv;
  logic [NCH*DW-1:0] main_cell, aux_cell;
  logic [MAXCH-1:0] bal_sw, s_sink, b_sink, bad_fet, open_wire;
  int n_errors, n_tests;

  bfd_diag #(.NCH(NCH)) uut (.clock(clock), .reset_n(reset_n), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .conv(conv), .main_cell_in(main_cell), .aux_cell_in(aux_cell),
    .bal_switch_out(bal_sw), .sense_sink_out(s_sink),
    .sense_source_out(s_src), .bal_sink_out(b_sink),
    .bal_source_out(b_src));
  bfd_cell_model #(.NCH(NCH)) fe (.bal_switch_in(bal_sw),
    .sense_sink_in(s_sink), .bal_sink_in(b_sink), .bad_fet(bad_fet),
    .open_wire(open_wire), .main_cell_out(main_cell),
    .aux_cell_out(aux_cell));

  // clock generation
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // read data taken in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic chk_reg(input string nm, input logic [3:0] a,
      input logic [15:0] exp);
    rd_reg(a);
    check(nm, rv, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask

  function automatic logic [15:0] ctrl(input logic [2:0] sel,
      input logic go, input logic ap, input logic [1:0] snk,
      input logic pz, input logic [3:0] thr);
    return {4'h0, thr, pz, snk, ap, go, sel};
  endfunction

  // bounded poll of one status bit
  task automatic wait_done(input int b);
    int i;
    for (i = 0; i < 60; i++) begin
      rd_reg(A_STAT);
      if (rv[b] === 1'b1)
        break;
    end
    if (i == 60) begin
      n_errors++;
      $display("[ERR] done bit %0d expected 1 seen 0", b);
      finish_test();
    end
  endtask

  // select, apply, then launch a switch check
  task automatic run_fet(input logic [7:0] tl, input logic [7:0] th,
      input logic [15:0] asel, input logic pz, input logic probe);
    wr_reg(A_AUXSEL, asel);
    wr_reg(A_TSL, {8'h00, tl});
    wr_reg(A_TSH, {8'h00, th});
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b1, 2'h0, pz, 4'h0));
    wr_reg(A_CTRL, ctrl(SEL_FET, 1'b1, 1'b0, 2'h0, pz, 4'h0));
    if (probe) begin
      rd_reg(A_STAT);
      check("stale done", rv & 16'h0003, 16'h0000);
    end
    wait_done(D_FET);
  endtask

  task automatic t_reset;
    check("switches", bal_sw, 16'h0000);
    check("sinks", s_sink | b_sink, 16'h0000);
    chk_reg("status", A_STAT, 16'h0000);
    chk_reg("aux result", A_AUXRES, AUX_DEFAULT);
    chk_reg("unmapped", 4'hf, 16'h0000);
    $display("test reset done");
  endtask

  task automatic t_fet_run;
    @(posedge clock);
    bad_fet <= 16'h0010;
    run_fet(8'h33, 8'h33, AS_ALL, 1'b1, 1'b0);
    check("done flags", rv & 16'h0003, 16'h0001);
    check("applied", bal_sw, 16'h3333);
    chk_reg("abort flag", A_MISC, 16'h0000);
    chk_reg("result low", A_FETL, 16'h0010);
    chk_reg("result high", A_FETH, 16'h0000);
    // odd group then even group; the bad switch sits in the odd group
    run_fet(8'h55, 8'h55, AS_ALL, 1'b1, 1'b0);
    chk_reg("odd low", A_FETL, 16'h0010);
    chk_reg("odd high", A_FETH, 16'h0000);
    run_fet(8'haa, 8'haa, AS_ALL, 1'b1, 1'b0);
    check("even applied", bal_sw, 16'haaaa);
    chk_reg("even low", A_FETL, 16'h0000);
    chk_reg("even high", A_FETH, 16'h0000);
    $display("test switch run done");
  endtask

  task automatic abort_case(input bfd_conv_t cv, input logic [7:0] tl,
      input logic [7:0] th, input logic [15:0] asel, input logic pz);
    @(posedge clock);
    conv <= cv;
    run_fet(tl, th, asel, pz, 1'b0);
    check("abort done", rv & 16'h0003, 16'h0003);
    chk_reg("abort flag", A_MISC, 16'h0001);
    chk_reg("abort low", A_FETL, 16'h00ff);
    chk_reg("abort high", A_FETH, 16'h00ff);
    wr_reg(A_MISC, 16'h0001);
    conv <= CV_OK;
  endtask

  task automatic t_aborts;
    abort_case(5'b11111, 8'h01, 8'h00, AS_ALL, 1'b0);
    abort_case(CV_OK, 8'h55, 8'hd5, AS_ALL, 1'b1);
    abort_case(CV_OK, 8'hc0, 8'h01, AS_ALL, 1'b1);
    abort_case(5'b01110, 8'h01, 8'h00, AS_ALL, 1'b1);
    abort_case(5'b10110, 8'h01, 8'h00, AS_ALL, 1'b1);
    abort_case(5'b11010, 8'h01, 8'h00, AS_ALL, 1'b1);
    abort_case(5'b11100, 8'h01, 8'h00, AS_ALL, 1'b1);
    abort_case(CV_OK, 8'h01, 8'h00, 16'h1011, 1'b1);
    abort_case(CV_OK, 8'h01, 8'h00, 16'h0a0c, 1'b1);
    $display("test aborts done");
  endtask

  // locked channel 3: result updated, then wiped by an abort
  task automatic t_locked;
    run_fet(8'h04, 8'h00, 16'h1003, 1'b1, 1'b1);
    chk_reg("locked result", A_FETL, 16'h0000);
    chk_reg("locked aux", A_AUXRES, 16'h0100);
    chk_reg("locked diag", A_DIAGAUX, 16'h0100);
    abort_case(5'b01110, 8'h04, 8'h00, 16'h1003, 1'b1);
    chk_reg("aux default", A_AUXRES, AUX_DEFAULT);
    $display("test locked done");
  endtask

  task automatic t_restore;
    wr_reg(A_TSL, 16'h0000);
    wr_reg(A_TSH, 16'h0000);
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b1, 2'h0, 1'b1, 4'h0));
    settle;
    check("cleared", bal_sw, 16'h0000);
    wr_reg(A_NORM, 16'h00a0);
    wr_reg(A_TSL, 16'h0003);
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b1, 2'h0, 1'b1, 4'h0));
    settle;
    check("test on", bal_sw, 16'h0003);
    @(posedge clock);
    conv <= 5'b11111;
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 4'h0));
    settle;
    check("normal back", bal_sw, 16'h00a0);
    // a write while ce is low must be lost
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(A_NORM, 16'h00ff);
    ce <= 1'b1;
    settle;
    check("frozen", bal_sw, 16'h00a0);
    chk_reg("frozen normal", A_NORM, 16'h00a0);
    conv <= CV_OK;
    $display("test restore done");
  endtask

  task automatic t_open_wire;
    @(posedge clock);
    open_wire <= 16'h1010;
    wr_reg(A_AUXSEL, AS_ALL);
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b0, 2'h1, 1'b0, 4'h4));
    settle;
    check("sense sinks", s_sink, 16'hffff);
    check("sense source", {15'h0, s_src}, 16'h0001);
    wr_reg(A_CTRL, ctrl(SEL_SOW, 1'b1, 1'b0, 2'h1, 1'b0, 4'h4));
    wait_done(D_SOW);
    chk_reg("sense low", A_SOWL, 16'h0010);
    chk_reg("sense high", A_SOWH, 16'h0010);
    wr_reg(A_AUXSEL, 16'h100d);
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b0, 2'h2, 1'b0, 4'h4));
    settle;
    check("bal sinks", b_sink, 16'hffff);
    check("bal source", {15'h0, b_src}, 16'h0001);
    wr_reg(A_CTRL, ctrl(SEL_BOW, 1'b1, 1'b0, 2'h2, 1'b0, 4'h4));
    wait_done(D_BOW);
    chk_reg("bal low", A_BOWL, 16'h0000);
    chk_reg("bal high", A_BOWH, 16'h0010);
    chk_reg("diag aux", A_DIAGAUX, 16'h0200);
    wr_reg(A_CTRL, ctrl(3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 4'h4));
    settle;
    check("sinks off", s_sink | b_sink, 16'h0000);
    $display("test open wire done");
  endtask

  // main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    conv = CV_OK;
    bad_fet = '0;
    open_wire = '0;
    n_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    t_reset;
    t_fet_run;
    t_aborts;
    t_locked;
    t_restore;
    t_open_wire;
    finish_test;
  end
endmodule
